//--- rtl/asc_pkg.sv
// constants and carrier types for the asynchronous serial channel core
// assumes one 100 MHz clock and a register port sampled synchronously
// Overview of operation
// R1 - modem status high bits show inverted pins
// R2 - enabled modem change flags raise level-four interrupt
// R3 - cts, dsr, dcd change flags on either edge
// R4 - ring flag only on low-to-high ring edge
// R5 - loop mode feeds status from modem control
// R6 - modem status read clears change flags only
// R7 - status set during read waits for strobe end
// R8 - recurring set status during read is cleared
// R9 - divider divides clock by sixteen-bit divisor
// R10 - writing either divisor byte reloads counter
// R11 - five to eight bits, right justified, zero fill
// R12 - shift on 16x clock, load buffer, set ready
// R13 - unread buffer overwritten and overrun flagged
// R14 - transmit same length, bit zero first
// R15 - holding write clears empty, transfer sets it
// R16 - transmitter empty low while shifting, wait shifter
// R17 - cpu writes holding only when empty flag set
// R18 - line status, data, holding empty, modem priority
// R19 - ident bit zero low pending, bits 2:1 source
// R20 - enable bits 0-3 per source, upper read zero
// R21 - disabled sources hidden, status still set
// R22 - start bit checked low at seven and half
// R23 - divisor access bit remaps offsets zero and one
// R24 - ident read or holding write clears holding interrupt
// R25 - ident codes 11, 10, 01, 00 with clear causes
package asc_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] ASC_OFS_DATA  = 3'h0;
  localparam logic [2:0] ASC_OFS_IEN   = 3'h1;
  localparam logic [2:0] ASC_OFS_IDENT = 3'h2;
  localparam logic [2:0] ASC_OFS_LCTL  = 3'h3;
  localparam logic [2:0] ASC_OFS_MCTL  = 3'h4;
  localparam logic [2:0] ASC_OFS_LSTAT = 3'h5;
  localparam logic [2:0] ASC_OFS_MSTAT = 3'h6;
  localparam logic [2:0] ASC_OFS_SCR   = 3'h7;
  // field positions
  localparam int ASC_LCTL_DIVISOR_ACCESS_BIT  = 7;
  localparam int ASC_LCTL_BREAK = 6;
  localparam int ASC_MCTL_LOOP  = 4;
  // ident codes, bit 0 included
  localparam logic [7:0] ASC_ID_NONE = 8'h01;
  localparam logic [7:0] ASC_ID_LINE = 8'h06;
  localparam logic [7:0] ASC_ID_DATA = 8'h04;
  localparam logic [7:0] ASC_ID_HOLDING_EMPTY_FLAG = 8'h02;
  localparam logic [7:0] ASC_ID_MDM  = 8'h00;
  // reset values
  localparam logic [7:0]  ASC_RST_ZERO  = 8'h00;
  localparam logic [15:0] ASC_RST_DIV   = 16'h0001;
  // sample counts at 16x
  localparam logic [3:0] ASC_HALF_BIT = 4'h7;
  localparam logic [3:0] ASC_FULL_BIT = 4'hF;

  typedef enum logic [1:0] {
    ASC_RX_IDLE  = 2'b00,
    ASC_RX_START = 2'b01,
    ASC_RX_DATA  = 2'b10,
    ASC_RX_STOP  = 2'b11
  } asc_rx_state_type;

  typedef enum logic [1:0] {
    ASC_TX_IDLE  = 2'b00,
    ASC_TX_START = 2'b01,
    ASC_TX_DATA  = 2'b10,
    ASC_TX_STOP  = 2'b11
  } asc_tx_state_type;

  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic ri_n;
    logic dcd_n;
  } asc_modem_in_type;

  typedef struct packed {
    logic dtr_n;
    logic rts_n;
    logic user_output_one_n;
    logic user_output_two_n;
  } asc_modem_out_type;

  typedef struct packed {
    logic [7:0]       ien;
    logic [7:0]       lctl;
    logic [7:0]       mctl;
    logic [7:0]       scr;
    logic [15:0]      divisor;
    logic [15:0]      div_cnt;
    logic             tick;
    logic [7:0]       rx_buf;
    logic             data_ready;
    logic             overrun;
    logic             frame_err;
    logic [3:0]       delta;
    logic [3:0]       mdm_prev;
    logic [3:0]       pend_set;
    logic             pend_ovr;
    logic             pend_frm;
    logic             pend_dr;
    logic             rd_prev;
    logic [2:0]       rd_addr;
    logic             holding_empty_flag_irq;
    logic [7:0]       hold;
    logic             hold_empty;
    asc_tx_state_type tx_state;
    logic [7:0]       tx_shift;
    logic [3:0]       tx_tick;
    logic [2:0]       tx_bit;
    logic             tx_line;
    asc_rx_state_type rx_state;
    logic [7:0]       rx_shift;
    logic [3:0]       rx_tick;
    logic [2:0]       rx_bit;
    logic             rx_prev;
    logic [7:0]       rd_data;
  } asc_state_type;
endpackage : asc_pkg

//--- rtl/asc_core.sv
// asynchronous serial channel: registers, divider, transmitter, receiver
// assumes the cpu port and modem pins are synchronous to ref_clk
`timescale 1ns/100ps
module asc_core (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  // cpu register port
  input  wire logic [2:0]            addr,
  input  wire logic                  write_strobe,
  input  wire logic [7:0]            write_data,
  input  wire logic                  read_strobe_n,
  output      logic [7:0]            read_data,
  output      logic                  interrupt,
  // serial and modem pins
  input  wire logic                  serial_input,
  output      logic                  serial_output,
  input  wire asc_pkg::asc_modem_in_type  modem_in,
  output      asc_pkg::asc_modem_out_type modem_out
);
  import asc_pkg::*;

  asc_state_type st;
  asc_state_type next_st;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] last_bit(input logic [1:0] wls);
    last_bit = 3'(4 + int'(wls));
  endfunction : last_bit

  function automatic logic [7:0] len_mask(input logic [1:0] wls);
    len_mask = 8'(9'h1FF >> (3 - int'(wls) + 1));
  endfunction : len_mask

  logic       rd_active;
  logic       rd_end;
  logic       wr_data;
  logic       divisor_access_bit;
  logic       loop_mode;
  logic [3:0] mdm_lvl;
  logic       rx_in;
  logic       line_irq;
  logic [7:0] ident;
  logic [7:0] lstat;
  logic       tx_idle;

  assign divisor_access_bit      = st.lctl[ASC_LCTL_DIVISOR_ACCESS_BIT];
  assign loop_mode = st.mctl[ASC_MCTL_LOOP];
  assign rd_active = !read_strobe_n;
  assign rd_end    = st.rd_prev && read_strobe_n;
  assign wr_data   = write_strobe && addr == ASC_OFS_DATA && !divisor_access_bit;
  assign tx_idle   = st.tx_state == ASC_TX_IDLE;
  // levels in order dcd, ri, dsr, cts
  assign mdm_lvl   = loop_mode ? {st.mctl[3], st.mctl[2], st.mctl[0], st.mctl[1]}  // [R5]
                               : ~{modem_in.dcd_n, modem_in.ri_n,
                                   modem_in.dsr_n, modem_in.cts_n};               // [R1]
  assign rx_in     = loop_mode ? st.tx_line : serial_input;
  assign line_irq  = st.overrun || st.frame_err;

  always_comb
  begin
    lstat = {1'b0, st.hold_empty && tx_idle, st.hold_empty, 1'b0,
             st.frame_err, 1'b0, st.overrun, st.data_ready};
    // disabled sources never surface
    if (st.ien[2] && line_irq)                                                 // [R18] [R21]
      ident = ASC_ID_LINE;                                                     // [R25]
    else if (st.ien[0] && st.data_ready)
      ident = ASC_ID_DATA;
    else if (st.ien[1] && st.holding_empty_flag_irq)
      ident = ASC_ID_HOLDING_EMPTY_FLAG;
    else if (st.ien[3] && |st.delta)                                           // [R2]
      ident = ASC_ID_MDM;
    else
      ident = ASC_ID_NONE;                                                     // [R19]
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [3:0] chg;
    chg = 4'h0;
    next_st = st;
    next_st.rd_prev = rd_active;
    next_st.tick = 1'b0;
    if (rd_active && !st.rd_prev)
      next_st.rd_addr = addr;

    // ---------------- baud divider ----------------
    // runs ahead of the writes so that a divisor write overrides the count
    if (st.div_cnt <= 16'h0001)
    begin
      next_st.div_cnt = st.divisor;                                            // [R9]
      next_st.tick = 1'b1;
    end
    else
      next_st.div_cnt = 16'(st.div_cnt - 16'h0001);

    // ---------------- cpu writes ----------------
    if (write_strobe)
    begin
      case (addr)
        ASC_OFS_DATA:
          if (divisor_access_bit)
          begin
            next_st.divisor[7:0] = write_data;
            next_st.div_cnt = {st.divisor[15:8], write_data};                  // [R10]
          end
          else
          begin
            next_st.hold = write_data;
            next_st.hold_empty = 1'b0;                                         // [R15]
            next_st.holding_empty_flag_irq = 1'b0;                                           // [R24]
          end
        ASC_OFS_IEN:
          if (divisor_access_bit)
          begin
            next_st.divisor[15:8] = write_data;
            next_st.div_cnt = {write_data, st.divisor[7:0]};                   // [R10] [R23]
          end
          else
            next_st.ien = {4'h0, write_data[3:0]};                             // [R20]
        ASC_OFS_LCTL: next_st.lctl = write_data;
        ASC_OFS_MCTL: next_st.mctl = {3'h0, write_data[4:0]};
        ASC_OFS_SCR:  next_st.scr = write_data;
        default: ;
      endcase
    end

    // ---------------- cpu read data ----------------
    if (rd_active && !st.rd_prev)
    begin
      case (addr)
        ASC_OFS_DATA:  next_st.rd_data = divisor_access_bit ? st.divisor[7:0] : st.rx_buf;  // [R23]
        ASC_OFS_IEN:   next_st.rd_data = divisor_access_bit ? st.divisor[15:8] : st.ien;
        ASC_OFS_IDENT: next_st.rd_data = ident;
        ASC_OFS_LCTL:  next_st.rd_data = st.lctl;
        ASC_OFS_MCTL:  next_st.rd_data = st.mctl;
        ASC_OFS_LSTAT: next_st.rd_data = lstat;
        ASC_OFS_MSTAT: next_st.rd_data = {mdm_lvl, st.delta};
        ASC_OFS_SCR:   next_st.rd_data = st.scr;
        default:       next_st.rd_data = ASC_RST_ZERO;
      endcase
      if (addr == ASC_OFS_IDENT && ident == ASC_ID_HOLDING_EMPTY_FLAG)
        next_st.holding_empty_flag_irq = 1'b0;                                               // [R24]
    end

    // ---------------- modem change detect ----------------
    next_st.mdm_prev = mdm_lvl;
    chg[0] = mdm_lvl[0] != st.mdm_prev[0];                                    // [R3]
    chg[1] = mdm_lvl[1] != st.mdm_prev[1];
    chg[3] = mdm_lvl[3] != st.mdm_prev[3];
    // level bit is active-high ring, so trailing pin edge is level falling
    chg[2] = st.mdm_prev[2] && !mdm_lvl[2];                                   // [R4]

    // ---------------- transmitter ----------------
    if (st.tick)
    begin
      case (st.tx_state)
        ASC_TX_IDLE:
          if (!st.hold_empty)                                                  // [R16]
          begin
            next_st.tx_shift = st.hold & len_mask(st.lctl[1:0]);              // [R14]
            next_st.hold_empty = 1'b1;                                         // [R15]
            next_st.holding_empty_flag_irq = 1'b1;
            next_st.tx_state = ASC_TX_START;
            next_st.tx_tick = 4'h0;
            next_st.tx_line = 1'b0;
          end
        ASC_TX_START:
        begin
          next_st.tx_tick = 4'(st.tx_tick + 4'h1);
          if (st.tx_tick == ASC_FULL_BIT)
          begin
            next_st.tx_state = ASC_TX_DATA;
            next_st.tx_bit = 3'h0;
            next_st.tx_line = st.tx_shift[0];                                  // [R14]
          end
        end
        ASC_TX_DATA:
        begin
          next_st.tx_tick = 4'(st.tx_tick + 4'h1);
          if (st.tx_tick == ASC_FULL_BIT)
          begin
            if (st.tx_bit == last_bit(st.lctl[1:0]))
            begin
              next_st.tx_state = ASC_TX_STOP;
              next_st.tx_line = 1'b1;
            end
            else
            begin
              next_st.tx_bit = 3'(st.tx_bit + 3'h1);
              next_st.tx_shift = {1'b0, st.tx_shift[7:1]};
              next_st.tx_line = st.tx_shift[1];
            end
          end
        end
        ASC_TX_STOP:
        begin
          next_st.tx_tick = 4'(st.tx_tick + 4'h1);
          if (st.tx_tick == ASC_FULL_BIT)
            next_st.tx_state = ASC_TX_IDLE;
        end
        default: next_st.tx_state = ASC_TX_IDLE;
      endcase
    end

    // ---------------- receiver ----------------
    if (st.tick)
    begin
      next_st.rx_prev = rx_in;
      case (st.rx_state)
        ASC_RX_IDLE:
          if (st.rx_prev && !rx_in)
          begin
            next_st.rx_state = ASC_RX_START;                                   // [R22]
            next_st.rx_tick = 4'h0;
          end
        ASC_RX_START:
        begin
          next_st.rx_tick = 4'(st.rx_tick + 4'h1);
          if (st.rx_tick == ASC_HALF_BIT)
          begin
            // noise spikes are rejected here
            if (rx_in)
              next_st.rx_state = ASC_RX_IDLE;                                  // [R22]
            else
            begin
              next_st.rx_state = ASC_RX_DATA;
              next_st.rx_tick = 4'h0;
              next_st.rx_bit = 3'h0;
              next_st.rx_shift = ASC_RST_ZERO;
            end
          end
        end
        ASC_RX_DATA:
        begin
          next_st.rx_tick = 4'(st.rx_tick + 4'h1);
          if (st.rx_tick == ASC_FULL_BIT)
          begin
            next_st.rx_shift[st.rx_bit] = rx_in;                               // [R11] [R12]
            next_st.rx_bit = 3'(st.rx_bit + 3'h1);
            if (st.rx_bit == last_bit(st.lctl[1:0]))
              next_st.rx_state = ASC_RX_STOP;
          end
        end
        ASC_RX_STOP:
        begin
          next_st.rx_tick = 4'(st.rx_tick + 4'h1);
          if (st.rx_tick == ASC_FULL_BIT)
          begin
            next_st.rx_state = ASC_RX_IDLE;
            next_st.rx_buf = st.rx_shift;                                      // [R12] [R13]
            next_st.pend_dr = 1'b1;
            next_st.pend_ovr = st.data_ready;                                  // [R13]
            next_st.pend_frm = !rx_in;
          end
        end
        default: next_st.rx_state = ASC_RX_IDLE;
      endcase
    end
    if (st.rx_state == ASC_RX_STOP && next_st.rx_state == ASC_RX_IDLE)
      ;
    else
    begin
      next_st.pend_dr  = st.pend_dr && rd_active;
      next_st.pend_ovr = st.pend_ovr && rd_active;
      next_st.pend_frm = st.pend_frm && rd_active;
    end

    // ---------------- status set and clear ----------------
    // a set while the strobe is low is parked and applied at the trailing edge
    if (rd_active)
      next_st.pend_set = st.pend_set | chg;                                    // [R7]
    else if (rd_end)
      next_st.pend_set = 4'h0;
    if (!rd_active && !rd_end)
    begin
      next_st.delta = st.delta | chg;
      if (next_st.pend_dr)
        next_st.data_ready = 1'b1;
      next_st.overrun = st.overrun | next_st.pend_ovr;
      next_st.frame_err = st.frame_err | next_st.pend_frm;
      next_st.pend_dr = 1'b0;
      next_st.pend_ovr = 1'b0;
      next_st.pend_frm = 1'b0;
    end
    if (rd_end)
    begin
      if (st.rd_addr == ASC_OFS_MSTAT)
        // parked sets on already-set flags clear with them
        next_st.delta = (st.pend_set | chg) & ~st.delta;                       // [R6] [R8]
      else
        next_st.delta = st.delta | st.pend_set | chg;                          // [R7]
      if (st.rd_addr == ASC_OFS_LSTAT)
      begin
        next_st.overrun = st.pend_ovr && !st.overrun;                          // [R8]
        next_st.frame_err = st.pend_frm && !st.frame_err;
      end
      else
      begin
        next_st.overrun = st.overrun | st.pend_ovr;                            // [R7]
        next_st.frame_err = st.frame_err | st.pend_frm;
      end
      if (st.rd_addr == ASC_OFS_DATA && !divisor_access_bit)
        next_st.data_ready = st.pend_dr;
      else
        next_st.data_ready = st.data_ready | st.pend_dr;
      next_st.pend_dr = 1'b0;
      next_st.pend_ovr = 1'b0;
      next_st.pend_frm = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
      st.divisor <= ASC_RST_DIV;
      st.div_cnt <= ASC_RST_DIV;
      st.hold_empty <= 1'b1;
      // empty holding register arms its interrupt once enabled
      st.holding_empty_flag_irq <= 1'b1;
      st.tx_line <= 1'b1;
      st.rx_prev <= 1'b1;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign read_data     = st.rd_data;
  assign interrupt     = ident != ASC_ID_NONE;                                 // [R21]
  assign serial_output = loop_mode ? 1'b1 : (st.tx_line && !st.lctl[ASC_LCTL_BREAK]);
  // loop mode parks modem outputs inactive
  assign modem_out.dtr_n  = !(st.mctl[0] && !loop_mode);
  assign modem_out.rts_n  = !(st.mctl[1] && !loop_mode);
  assign modem_out.user_output_one_n = !(st.mctl[2] && !loop_mode);
  assign modem_out.user_output_two_n = !(st.mctl[3] && !loop_mode);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_ident_low;
    @(posedge ref_clk) disable iff (!arst_n) interrupt |-> !ident[0];
  endproperty
  a_ident_low: assert property (p_ident_low) else $error("pending without ident");   // [R19]

  property p_ien_upper;
    @(posedge ref_clk) disable iff (!arst_n) st.ien[7:4] == 4'h0;
  endproperty
  a_ien_upper: assert property (p_ien_upper) else $error("enable upper bits set"); // [R20]

  property p_write_clears;
    @(posedge ref_clk) disable iff (!arst_n) wr_data |=> !st.hold_empty;
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("holding flag kept"); // [R15]

  property p_loop_map;
    @(posedge ref_clk) disable iff (!arst_n)
      loop_mode |-> mdm_lvl == {st.mctl[3], st.mctl[2], st.mctl[0], st.mctl[1]};
  endproperty
  a_loop_map: assert property (p_loop_map) else $error("loop status wrong");       // [R5]

  property p_no_set_in_read;
    @(posedge ref_clk) disable iff (!arst_n)
      rd_active && st.rd_prev && $past(rd_active) |=> st.delta == $past(st.delta);
  endproperty
  a_no_set_in_read: assert property (p_no_set_in_read) else $error("set during read"); // [R7]

  property p_line_first;
    @(posedge ref_clk) disable iff (!arst_n)
      st.ien[2] && line_irq |-> ident == ASC_ID_LINE;
  endproperty
  a_line_first: assert property (p_line_first) else $error("priority wrong");      // [R18]

  property p_mdm_irq;
    @(posedge ref_clk) disable iff (!arst_n) st.ien[3] && |st.delta |-> interrupt;
  endproperty
  a_mdm_irq: assert property (p_mdm_irq) else $error("modem interrupt missing");   // [R2]

  property p_transmitter_empty_flag_busy;
    @(posedge ref_clk) disable iff (!arst_n) !tx_idle && !st.hold_empty |=> !st.hold_empty;
  endproperty
  a_transmitter_empty_flag_busy: assert property (p_transmitter_empty_flag_busy) else $error("held byte moved while shifting"); // [R16]

  property p_upper_len;
    @(posedge ref_clk) disable iff (!arst_n)
      st.rx_state == ASC_RX_STOP |-> (st.rx_shift & ~len_mask(st.lctl[1:0])) == 8'h00;
  endproperty
  a_upper_len: assert property (p_upper_len) else $error("upper bits not zero");    // [R11]
endmodule : asc_core

//--- testbench/asc_modem_partner.sv
// modem-side model: drives the serial input and modem lines, decodes serial output
// assumes bit_clks, left at its default of 32 by the bench, is sixteen times the programmed divisor
`timescale 1ns/100ps
module asc_modem_partner
  import asc_pkg::*;
(
  // clock
  input  wire logic             ref_clk,
  // line side
  output      logic             serial_input,
  output      asc_modem_in_type modem_in,
  input  wire logic             serial_output
);
  int bit_clks = 32;

  initial
  begin
    serial_input = 1'b1;
    modem_in     = 4'hF;
  end

  task automatic set_modem(input logic [3:0] v);
    @(posedge ref_clk);
    modem_in <= v;
  endtask : set_modem

  // start low, data bit zero first, one stop bit, then idle
  task automatic send_char(input logic [7:0] d, input int n);
    logic [9:0] frame;
    frame = {1'b1, d, 1'b0} | (10'h3FF << (n + 1));
    for (int i = 0; i < n + 2; i++)
    begin
      @(posedge ref_clk);
      serial_input <= frame[i];
      repeat (bit_clks - 1) @(posedge ref_clk);
    end
    repeat (bit_clks) @(posedge ref_clk);
  endtask : send_char

  // short low spike, well under half a bit
  task automatic pulse_low(input int clks);
    @(posedge ref_clk);
    serial_input <= 1'b0;
    repeat (clks) @(posedge ref_clk);
    serial_input <= 1'b1;
  endtask : pulse_low

  // samples at bit centres on the falling clock edge, away from output updates
  task automatic recv_char(output logic [7:0] d, output logic stop, input int n);
    d = 8'h00;
    @(negedge serial_output);
    repeat (bit_clks / 2) @(negedge ref_clk);
    for (int i = 0; i < n; i++)
    begin
      repeat (bit_clks) @(negedge ref_clk);
      d[i] = serial_output;
    end
    repeat (bit_clks) @(negedge ref_clk);
    stop = serial_output;
  endtask : recv_char
endmodule : asc_modem_partner

//--- testbench/asc_core_tb_top.sv
// self-checking bench for the serial channel core through its register port
// assumes divisor 2, so one bit lasts 32 reference clocks
`timescale 1ns/100ps
`define chk(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module asc_core_tb_top;
  import asc_pkg::*;
  logic              ref_clk = 1'b0;
  logic              arst_n;
  logic [2:0]        addr;
  logic              write_strobe;
  logic [7:0]        write_data;
  logic              read_strobe_n;
  logic [7:0]        read_data;
  logic              interrupt;
  logic              serial_input;
  logic              serial_output;
  asc_modem_in_type  modem_in;
  asc_modem_out_type modem_out;
  int                errors = 0;
  int                total_checks = 0;
  int                rd_extra = 0;
  logic [7:0]        v;
  logic [7:0]        rx;
  logic              stop;
  logic [7:0]        loop_mctl [4] = '{8'h11, 8'h12, 8'h14, 8'h18};
  logic [3:0]        loop_msr [4] = '{4'h2, 4'h1, 4'h4, 4'h8};

  always #5 ref_clk = ~ref_clk;

  asc_core i_asc_core (
    .ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .write_strobe(write_strobe),
    .write_data(write_data), .read_strobe_n(read_strobe_n), .read_data(read_data),
    .interrupt(interrupt), .serial_input(serial_input), .serial_output(serial_output),
    .modem_in(modem_in), .modem_out(modem_out));

  asc_modem_partner i_asc_modem_partner (
    .ref_clk(ref_clk), .serial_input(serial_input), .modem_in(modem_in),
    .serial_output(serial_output));

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr         <= a;
    write_data   <= d;
    write_strobe <= 1'b1;
    @(posedge ref_clk);
    write_strobe <= 1'b0;
  endtask : wr

  // strobe held low rd_extra more cycles to open a window for status races
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr          <= a;
    read_strobe_n <= 1'b0;
    repeat (2 + rd_extra) @(posedge ref_clk);
    d = read_data;
    read_strobe_n <= 1'b1;
  endtask : rd

  task automatic wait_idle();
    for (int i = 0; i < 300; i++)
    begin
      rd(ASC_OFS_LSTAT, v);
      if (v === 8'h60)
        return;
    end
    `chk(v, 8'h60)
  endtask : wait_idle

  task automatic report_and_stop();
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    report_and_stop();
  end

  initial
  begin
    arst_n = 1'b0; write_strobe = 1'b0; read_strobe_n = 1'b1;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    // ----------------------------------------------------------------
    // registers and interrupt ident
    // ----------------------------------------------------------------
    rd(ASC_OFS_LSTAT, v); `chk(v, 8'h60)
    rd(ASC_OFS_IDENT, v); `chk(v, ASC_ID_NONE)
    wr(ASC_OFS_IEN, 8'hFF); rd(ASC_OFS_IEN, v); `chk(v, 8'h0F)
    `chk(interrupt, 1'b1)
    rd(ASC_OFS_IDENT, v); `chk(v, ASC_ID_HOLDING_EMPTY_FLAG)
    rd(ASC_OFS_IDENT, v); `chk(v, ASC_ID_NONE)
    `chk(interrupt, 1'b0)
    wr(ASC_OFS_IEN, 8'h00);
    wr(ASC_OFS_SCR, 8'hA5); rd(ASC_OFS_SCR, v); `chk(v, 8'hA5)
    wr(ASC_OFS_LCTL, 8'h80); wr(ASC_OFS_DATA, 8'h34); wr(ASC_OFS_IEN, 8'h12);
    rd(ASC_OFS_DATA, v); `chk(v, 8'h34)
    rd(ASC_OFS_IEN, v); `chk(v, 8'h12)
    wr(ASC_OFS_IEN, 8'h00); wr(ASC_OFS_DATA, 8'h02); wr(ASC_OFS_LCTL, 8'h03);
    // ----------------------------------------------------------------
    // modem status
    // ----------------------------------------------------------------
    rd(ASC_OFS_MSTAT, v);
    i_asc_modem_partner.set_modem(4'h0);
    rd(ASC_OFS_MSTAT, v); `chk(v, 8'hFB)
    rd(ASC_OFS_MSTAT, v); `chk(v, 8'hF0)
    i_asc_modem_partner.set_modem(4'h2);
    rd(ASC_OFS_MSTAT, v); `chk(v, 8'hB4)
    wr(ASC_OFS_IEN, 8'h08); i_asc_modem_partner.set_modem(4'hA);
    repeat (2) @(posedge ref_clk);
    `chk(interrupt, 1'b1)
    rd(ASC_OFS_IDENT, v); `chk(v, ASC_ID_MDM)
    wr(ASC_OFS_IEN, 8'h00); @(negedge ref_clk);
    `chk(interrupt, 1'b0)
    rd(ASC_OFS_MSTAT, v); `chk(v, 8'hA1)
    i_asc_modem_partner.set_modem(4'h2);
    rd_extra = 4;
    fork
      rd(ASC_OFS_MSTAT, v);
      begin repeat (2) @(posedge ref_clk); i_asc_modem_partner.set_modem(4'hA); end
    join
    rd_extra = 0;
    `chk(v, 8'hB1)
    rd(ASC_OFS_MSTAT, v); `chk(v, 8'hA0)
    rd_extra = 4;
    fork
      rd(ASC_OFS_MSTAT, v);
      begin repeat (2) @(posedge ref_clk); i_asc_modem_partner.set_modem(4'h2); end
    join
    rd_extra = 0;
    `chk(v, 8'hA0)
    rd(ASC_OFS_MSTAT, v); `chk(v, 8'hB1)
    for (int i = 0; i < 4; i++)
    begin
      wr(ASC_OFS_MCTL, loop_mctl[i]); rd(ASC_OFS_MSTAT, v); `chk(v[7:4], loop_msr[i])
      `chk(modem_out, 4'hF)
    end
    wr(ASC_OFS_MCTL, 8'h03); @(negedge ref_clk);
    `chk(modem_out, 4'h3)
    // ----------------------------------------------------------------
    // transmit: back to back, then five-bit length
    // ----------------------------------------------------------------
    fork
      begin
        i_asc_modem_partner.recv_char(rx, stop, 8); `chk(rx, 8'h3C)
        i_asc_modem_partner.recv_char(rx, stop, 8); `chk(rx, 8'hC3)
      end
      begin
        wr(ASC_OFS_DATA, 8'h3C); repeat (4) @(posedge ref_clk);
        rd(ASC_OFS_LSTAT, v); `chk(v, 8'h20)
        wr(ASC_OFS_DATA, 8'hC3); rd(ASC_OFS_LSTAT, v); `chk(v, 8'h00)
      end
    join
    wait_idle();
    wr(ASC_OFS_LCTL, 8'h00);
    fork
      i_asc_modem_partner.recv_char(rx, stop, 5);
      wr(ASC_OFS_DATA, 8'hFF);
    join
    `chk({stop, rx}, 9'h11F)
    wait_idle();
    // ----------------------------------------------------------------
    // receive, overrun, priorities, false start
    // ----------------------------------------------------------------
    i_asc_modem_partner.send_char(8'h13, 5);
    rd(ASC_OFS_LSTAT, v); `chk(v, 8'h61)
    rd(ASC_OFS_DATA, v); `chk(v, 8'h13)
    wr(ASC_OFS_LCTL, 8'h03);
    i_asc_modem_partner.send_char(8'h5A, 8);
    i_asc_modem_partner.send_char(8'hA6, 8);
    wr(ASC_OFS_IEN, 8'h07);
    rd(ASC_OFS_IDENT, v); `chk(v, ASC_ID_LINE)
    rd(ASC_OFS_LSTAT, v); `chk(v, 8'h63)
    rd(ASC_OFS_IDENT, v); `chk(v, ASC_ID_DATA)
    rd(ASC_OFS_DATA, v); `chk(v, 8'hA6)
    rd(ASC_OFS_IDENT, v); `chk(v, ASC_ID_HOLDING_EMPTY_FLAG)
    rd(ASC_OFS_IDENT, v); `chk(v, ASC_ID_NONE)
    wr(ASC_OFS_IEN, 8'h00);
    i_asc_modem_partner.pulse_low(4);
    repeat (400) @(posedge ref_clk);
    rd(ASC_OFS_LSTAT, v); `chk(v, 8'h60)
    report_and_stop();
  end
endmodule : asc_core_tb_top
